// ==== pkg/rrf_pkg.sv ====
// constants and types shared by the render register front end
package rrf_pkg;
    localparam int TAG_W = 12;
    localparam int OFS_W = 4;
    localparam int GRP_W = 8;
    localparam int DATA_W = 32;

    // register tags: major group above the low four offset bits
    localparam logic [11:0] TAG_RASTER_Y_EXTENT = 12'h015;
    localparam logic [11:0] TAG_COMPLETION_WAIT = 12'h017;
    localparam logic [11:0] TAG_RASTER_X_EXTENT = 12'h019;
    localparam logic [11:0] TAG_FRAGMENT_ORIGIN = 12'h039;
    localparam logic [11:0] TAG_TEXEL_VALUE = 12'h0c0;
    localparam logic [11:0] TAG_LB_UPDATE_CTRL = 12'h130;
    localparam logic [11:0] TAG_DEPTH_START_UPPER = 12'h136;
    localparam logic [11:0] TAG_DEPTH_START_LOWER = 12'h137;
    localparam logic [11:0] TAG_COLOR_CONVERT = 12'h1e0;

    // localbuffer update control fields
    localparam int LB_FORCE_BIT = 3;
    localparam int LB_BLOCK_BIT = 18;
    // colour conversion and chroma fields
    localparam int CC_ENABLE_BIT = 0;
    localparam int CC_MODE_LO = 1;
    localparam int CC_SOURCE_BIT = 3;
    localparam int CC_FAIL_ACTION_BIT = 4;
    localparam int CC_DISCARD_BIT = 5;
    // extent fields: 12-bit two's complement min in low half, max in high half
    localparam int EXT_W = 12;
    localparam int EXT_MAX_LO = 16;
    // depth start: upper holds integer bits, lower holds 11-bit fraction at top
    localparam int DEPTH_FRAC_W = 11;
    localparam int DEPTH_INT_W = 17;
    localparam int DEPTH_FRAC_LO = 21;
    // origin fields: 16-bit x low, y high
    localparam int ORG_W = 16;
    localparam int ORG_Y_LO = 16;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [31:0] UNREAD_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        RRF_CHROMA_OFF,
        RRF_CHROMA_PASS_IN,
        RRF_CHROMA_FAIL_IN,
        RRF_CHROMA_RSVD
    } rrf_chroma_mode_t;

    typedef enum logic [1:0] {
        RRF_KIND_CONTROL,
        RRF_KIND_COMMAND,
        RRF_KIND_MIXED,
        RRF_KIND_OUTPUT
    } rrf_kind_t;
endpackage : rrf_pkg

// ==== pkg/rrf_tag_if.sv ====
// tag classification signals between the decoder and the register bank
`timescale 1ns/1ps
interface rrf_tag_if;
    logic [11:0] tag;
    logic [7:0] group;
    logic [3:0] offset;
    rrf_pkg::rrf_kind_t kind;
    logic readable;
    logic known;

    modport decoder (input tag, output group, output offset, output kind, output readable,
        output known);
    modport bank (output tag, input group, input offset, input kind, input readable,
        input known);
endinterface : rrf_tag_if

// ==== verilog/rrf_tag_decoder.sv ====
// register tag decoder: group, offset, type and read-back class
`timescale 1ns/1ps
module rrf_tag_decoder (
    rrf_tag_if.decoder tif
);
    always_comb begin
        tif.group = tif.tag[rrf_pkg::TAG_W-1:rrf_pkg::OFS_W];
        tif.offset = tif.tag[3:0];
        tif.kind = rrf_pkg::RRF_KIND_CONTROL;
        tif.readable = 1'b0;
        tif.known = 1'b1;
        unique case (tif.tag)
            rrf_pkg::TAG_COMPLETION_WAIT: begin
                tif.kind = rrf_pkg::RRF_KIND_COMMAND;
            end
            rrf_pkg::TAG_RASTER_Y_EXTENT, rrf_pkg::TAG_RASTER_X_EXTENT,
            rrf_pkg::TAG_FRAGMENT_ORIGIN, rrf_pkg::TAG_TEXEL_VALUE,
            rrf_pkg::TAG_LB_UPDATE_CTRL, rrf_pkg::TAG_DEPTH_START_UPPER,
            rrf_pkg::TAG_DEPTH_START_LOWER, rrf_pkg::TAG_COLOR_CONVERT: begin
                tif.readable = 1'b1;
            end
            default: begin
                tif.known = 1'b0;
            end
        endcase
    end
endmodule : rrf_tag_decoder

// ==== verilog/rrf_front_end.sv ====
// render register front end: tag writes, read-back and pipeline controls
`timescale 1ns/1ps
module rrf_front_end (
    input wire logic clk,
    input wire logic rst,
    // host tag port, one word per cycle from the input FIFO or DMA
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [11:0] wr_tag,
    input wire logic [31:0] wr_data,
    input wire logic rd_valid,
    input wire logic [11:0] rd_tag,
    output logic [31:0] rd_data,
    output logic rd_ack,
    output logic rd_refused,
    // completion wait
    input wire logic fb_writes_pending,
    output logic pipe_stall,
    output logic wait_cmd_pulse,
    // localbuffer update decision
    input wire logic lb_write_enable,
    input wire logic stencil_pass,
    input wire logic depth_pass,
    input wire logic unit_enables,
    output logic lb_update,
    // fragment origin and fill limits
    input wire logic frag_valid,
    input wire logic [15:0] frag_x,
    input wire logic [15:0] frag_y,
    output logic [15:0] screen_x,
    output logic [15:0] screen_y,
    output logic screen_valid,
    output logic frag_inside,
    // colour conversion, chroma test and depth start
    input wire logic [31:0] texel_in,
    input wire logic [31:0] texel_converted,
    input wire logic chroma_in_bounds_in,
    input wire logic chroma_in_bounds_out,
    output logic [31:0] texel_value,
    output logic convert_enable,
    output logic suppress_plot,
    output logic suppress_texture,
    output logic texel_pass,
    output logic [27:0] depth_start
);
    rrf_tag_if wr_if ();
    rrf_tag_if rd_if ();

    rrf_tag_decoder u_wr_dec (
        .tif(wr_if.decoder)
    );
    rrf_tag_decoder u_rd_dec (
        .tif(rd_if.decoder)
    );

    assign wr_if.tag = wr_tag;
    assign rd_if.tag = rd_tag;

    logic [31:0] y_ext_q, y_ext_d;
    logic [31:0] x_ext_q, x_ext_d;
    logic [31:0] origin_q, origin_d;
    logic [31:0] texel_q, texel_d;
    logic [31:0] lbctl_q, lbctl_d;
    logic [31:0] zu_q, zu_d;
    logic [31:0] zl_q, zl_d;
    logic [31:0] yuv_q, yuv_d;
    logic wait_q, wait_d;
    logic [31:0] rd_data_q, rd_data_d;
    logic rd_ack_q, rd_ack_d;
    logic rd_refused_q, rd_refused_d;
    logic [15:0] sx_q, sx_d;
    logic [15:0] sy_q, sy_d;
    logic sv_q, sv_d;
    logic inside_q, inside_d;

    logic wr_take;
    logic wait_fire;

    // a stall blocks every later tag write, including more writes of the same group
    assign wr_ready = !wait_q;
    assign wr_take = wr_valid && wr_ready;
    assign wait_fire = wr_take && (wr_if.kind == rrf_pkg::RRF_KIND_COMMAND) &&
        (wr_tag == rrf_pkg::TAG_COMPLETION_WAIT);

    always_comb begin
        y_ext_d = y_ext_q;
        x_ext_d = x_ext_q;
        origin_d = origin_q;
        texel_d = texel_q;
        lbctl_d = lbctl_q;
        zu_d = zu_q;
        zl_d = zl_q;
        yuv_d = yuv_q;
        // data bits of the wait command are ignored
        wait_d = wait_q;
        if (wait_q && !fb_writes_pending) begin
            wait_d = 1'b0;
        end
        if (wait_fire) begin
            wait_d = 1'b1;
        end
        // mixed registers store like control ones; each download word overwrites the last
        if (wr_take && (wr_if.kind == rrf_pkg::RRF_KIND_CONTROL ||
            wr_if.kind == rrf_pkg::RRF_KIND_MIXED)) begin
            unique case (wr_tag)
                rrf_pkg::TAG_RASTER_Y_EXTENT: y_ext_d = wr_data;
                rrf_pkg::TAG_RASTER_X_EXTENT: x_ext_d = wr_data;
                rrf_pkg::TAG_FRAGMENT_ORIGIN: origin_d = wr_data;
                rrf_pkg::TAG_TEXEL_VALUE: texel_d = wr_data;
                rrf_pkg::TAG_LB_UPDATE_CTRL: lbctl_d = wr_data;
                rrf_pkg::TAG_DEPTH_START_UPPER: zu_d = wr_data;
                rrf_pkg::TAG_DEPTH_START_LOWER: zl_d = wr_data;
                rrf_pkg::TAG_COLOR_CONVERT: yuv_d = wr_data;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            y_ext_q <= rrf_pkg::RESET_WORD;
            x_ext_q <= rrf_pkg::RESET_WORD;
            origin_q <= rrf_pkg::RESET_WORD;
            texel_q <= rrf_pkg::RESET_WORD;
            lbctl_q <= rrf_pkg::RESET_WORD;
            zu_q <= rrf_pkg::RESET_WORD;
            zl_q <= rrf_pkg::RESET_WORD;
            yuv_q <= rrf_pkg::RESET_WORD;
            wait_q <= 1'b0;
        end else begin
            y_ext_q <= y_ext_d;
            x_ext_q <= x_ext_d;
            origin_q <= origin_d;
            texel_q <= texel_d;
            lbctl_q <= lbctl_d;
            zu_q <= zu_d;
            zl_q <= zl_d;
            yuv_q <= yuv_d;
            wait_q <= wait_d;
        end
    end

    assign pipe_stall = wait_q;
    assign wait_cmd_pulse = wait_fire;

    // read-back: unreadable, command, output or unknown tags answer zero
    always_comb begin
        rd_ack_d = rd_valid;
        rd_refused_d = rd_valid && !rd_if.readable;
        rd_data_d = rrf_pkg::UNREAD_WORD;
        if (rd_valid && rd_if.readable && rd_if.kind != rrf_pkg::RRF_KIND_OUTPUT) begin
            unique case (rd_tag)
                rrf_pkg::TAG_RASTER_Y_EXTENT: rd_data_d = y_ext_q;
                rrf_pkg::TAG_RASTER_X_EXTENT: rd_data_d = x_ext_q;
                rrf_pkg::TAG_FRAGMENT_ORIGIN: rd_data_d = origin_q;
                rrf_pkg::TAG_TEXEL_VALUE: rd_data_d = texel_q;
                rrf_pkg::TAG_LB_UPDATE_CTRL: rd_data_d = lbctl_q;
                rrf_pkg::TAG_DEPTH_START_UPPER: rd_data_d = zu_q;
                rrf_pkg::TAG_DEPTH_START_LOWER: rd_data_d = zl_q;
                rrf_pkg::TAG_COLOR_CONVERT: rd_data_d = yuv_q;
                default: rd_data_d = rrf_pkg::UNREAD_WORD;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_q <= rrf_pkg::UNREAD_WORD;
            rd_ack_q <= 1'b0;
            rd_refused_q <= 1'b0;
        end else begin
            rd_data_q <= rd_data_d;
            rd_ack_q <= rd_ack_d;
            rd_refused_q <= rd_refused_d;
        end
    end

    assign rd_data = rd_data_q;
    assign rd_ack = rd_ack_q;
    assign rd_refused = rd_refused_q;

    // localbuffer update: block beats force, force beats test results
    logic force_local_update;
    logic block_local_update;
    assign force_local_update = lbctl_q[rrf_pkg::LB_FORCE_BIT];
    assign block_local_update = lbctl_q[rrf_pkg::LB_BLOCK_BIT];

    always_comb begin
        if (block_local_update) begin
            lb_update = 1'b0;
        end else if (force_local_update) begin
            lb_update = lb_write_enable;
        end else begin
            lb_update = lb_write_enable && unit_enables && stencil_pass && depth_pass;
        end
    end

    // fragment path: origin added; X and Y fill limits checked on the incoming frag_x/frag_y coords
    logic signed [11:0] x_min, x_max, y_min, y_max;
    logic signed [15:0] sx_w, sy_w;
    assign x_min = x_ext_q[rrf_pkg::EXT_W-1:0];
    assign x_max = x_ext_q[rrf_pkg::EXT_MAX_LO +: rrf_pkg::EXT_W];
    assign y_min = y_ext_q[rrf_pkg::EXT_W-1:0];
    assign y_max = y_ext_q[rrf_pkg::EXT_MAX_LO +: rrf_pkg::EXT_W];

    always_comb begin
        sx_w = frag_x + origin_q[rrf_pkg::ORG_W-1:0];
        sy_w = frag_y + origin_q[rrf_pkg::ORG_Y_LO +: rrf_pkg::ORG_W];
        sx_d = sx_w;
        sy_d = sy_w;
        sv_d = frag_valid;
        // limits apply to raster coordinates, before the origin shift
        inside_d = frag_valid &&
            ($signed(frag_x) >= 16'(x_min)) && ($signed(frag_x) <= 16'(x_max)) &&
            ($signed(frag_y) >= 16'(y_min)) && ($signed(frag_y) <= 16'(y_max));
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sx_q <= 16'h0000;
            sy_q <= 16'h0000;
            sv_q <= 1'b0;
            inside_q <= 1'b0;
        end else begin
            sx_q <= sx_d;
            sy_q <= sy_d;
            sv_q <= sv_d;
            inside_q <= inside_d;
        end
    end

    assign screen_x = sx_q;
    assign screen_y = sy_q;
    assign screen_valid = sv_q;
    assign frag_inside = inside_q;

    // colour conversion and chroma test
    rrf_pkg::rrf_chroma_mode_t chroma_check_select;
    logic chroma_check_source;
    logic chroma_fail_action;
    logic texel_discard_select;
    logic in_bounds;
    logic chroma_fail;
    assign convert_enable = yuv_q[rrf_pkg::CC_ENABLE_BIT];
    assign chroma_check_select = rrf_pkg::rrf_chroma_mode_t'(yuv_q[rrf_pkg::CC_MODE_LO +: 2]);
    assign chroma_check_source = yuv_q[rrf_pkg::CC_SOURCE_BIT];
    assign chroma_fail_action = yuv_q[rrf_pkg::CC_FAIL_ACTION_BIT];
    assign texel_discard_select = yuv_q[rrf_pkg::CC_DISCARD_BIT];
    assign in_bounds = chroma_check_source ? chroma_in_bounds_out : chroma_in_bounds_in;
    // converted data is taken from the texel_converted input when enabled, else texel_in
    logic [31:0] texel_value_q, texel_value_d;

    always_comb begin
        texel_value_d = convert_enable ? texel_converted : texel_in;
    end

    // registered so the texel word leaves on a flop, one cycle behind its inputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            texel_value_q <= rrf_pkg::RESET_WORD;
        end else begin
            texel_value_q <= texel_value_d;
        end
    end

    assign texel_value = texel_value_q;

    always_comb begin
        unique case (chroma_check_select)
            rrf_pkg::RRF_CHROMA_PASS_IN: chroma_fail = !in_bounds;
            rrf_pkg::RRF_CHROMA_FAIL_IN: chroma_fail = in_bounds;
            default: chroma_fail = 1'b0;
        endcase
    end

    assign suppress_plot = chroma_fail && !chroma_fail_action;
    assign suppress_texture = chroma_fail && chroma_fail_action;
    assign texel_pass = !(texel_discard_select && chroma_fail);

    // 17 integer bits from upper part, 11 fraction bits from top of lower part
    assign depth_start = {zu_q[rrf_pkg::DEPTH_INT_W-1:0],
        zl_q[rrf_pkg::DEPTH_FRAC_LO +: rrf_pkg::DEPTH_FRAC_W]};
endmodule : rrf_front_end

// ==== tb/rrf_checker.sv ====
// port-level assertions for the render register front end
`timescale 1ns/1ps
module rrf_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [11:0] wr_tag,
    input wire logic rd_valid,
    input wire logic [11:0] rd_tag,
    input wire logic [31:0] rd_data,
    input wire logic rd_ack,
    input wire logic rd_refused,
    input wire logic fb_writes_pending,
    input wire logic pipe_stall,
    input wire logic wait_cmd_pulse,
    input wire logic lb_write_enable,
    input wire logic stencil_pass,
    input wire logic lb_update,
    input wire logic frag_valid,
    input wire logic screen_valid,
    input wire logic suppress_plot,
    input wire logic suppress_texture
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_wait_taken;
        wr_valid && wr_ready && wr_tag == rrf_pkg::TAG_COMPLETION_WAIT;
    endsequence
    sequence s_drained;
        pipe_stall && !fb_writes_pending;
    endsequence
    a_wait_stalls: assert property (s_wait_taken |=> pipe_stall)
        else $error("no stall after wait command");
    a_stall_blocks: assert property (pipe_stall |-> !wr_ready)
        else $error("write accepted while stalled");
    a_stall_drains: assert property (s_drained |=> !pipe_stall)
        else $error("stall kept after writes drained");
    a_stall_waits: assert property (pipe_stall && fb_writes_pending |=> pipe_stall)
        else $error("stall left with writes pending");
    a_pulse_cause: assert property (wait_cmd_pulse |-> s_wait_taken)
        else $error("wait pulse without wait write");
    a_read_answered: assert property (rd_valid |=> rd_ack)
        else $error("read not acknowledged");
    a_ack_cause: assert property (rd_ack |-> $past(rd_valid))
        else $error("acknowledge without read");
    a_refused_quiet: assert property (rd_refused |-> rd_ack && rd_data == rrf_pkg::UNREAD_WORD)
        else $error("refused read leaked data");
    a_force_needs_we: assert property (lb_update && !stencil_pass |-> lb_write_enable)
        else $error("forced update without write enable");
    a_frag_latency: assert property (frag_valid |=> screen_valid)
        else $error("screen coordinates late");
    a_chroma_single: assert property (!(suppress_plot && suppress_texture))
        else $error("both suppressions at once");
endmodule : rrf_checker

bind rrf_front_end rrf_checker chk (.clk, .rst, .wr_valid, .wr_ready, .wr_tag, .rd_valid,
    .rd_tag, .rd_data, .rd_ack, .rd_refused, .fb_writes_pending, .pipe_stall, .wait_cmd_pulse,
    .lb_write_enable, .stencil_pass, .lb_update, .frag_valid, .screen_valid, .suppress_plot,
    .suppress_texture);

// ==== tb/rrf_host_model.sv ====
// host model: feeds tag words as the input fifo would, and reads back
`timescale 1ns/1ps
module rrf_host_model (
    input wire logic clk,
    input wire logic wr_ready,
    input wire logic [31:0] rd_data,
    input wire logic rd_ack,
    input wire logic rd_refused,
    output logic wr_valid,
    output logic [11:0] wr_tag,
    output logic [31:0] wr_data,
    output logic rd_valid,
    output logic [11:0] rd_tag
);
    initial begin
        {wr_valid, rd_valid} = 2'h0;
        {wr_tag, rd_tag, wr_data} = 56'h0;
    end
    // calls in a row keep valid high, as a dma burst of one group does
    task automatic wr(input logic [11:0] t, input logic [31:0] d, output bit ok);
        int n;
        @(negedge clk);
        {wr_valid, wr_tag, wr_data} = {1'b1, t, d};
        ok = 1'b0;
        for (n = 0; n < 200 && !ok; n++) begin
            @(posedge clk);
            ok = wr_ready;
        end
    endtask : wr
    // released lines flip so a stale value never looks valid
    task automatic idle();
        @(negedge clk);
        {wr_valid, wr_tag, wr_data} = {1'b0, ~wr_tag, ~wr_data};
    endtask : idle
    task automatic rd(input logic [11:0] t, output logic [31:0] d, output logic a,
        output logic r);
        @(negedge clk);
        {rd_valid, rd_tag} = {1'b1, t};
        @(negedge clk);
        {rd_valid, rd_tag} = {1'b0, ~t};
        {d, a, r} = {rd_data, rd_ack, rd_refused};
    endtask : rd
endmodule : rrf_host_model

// ==== tb/render_register_front_end_bench.sv ====
// self-checking bench for the render register front end
`timescale 1ns/1ps
module render_register_front_end_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr_valid, wr_ready, rd_valid, rd_ack, rd_refused, fb_writes_pending, pipe_stall;
    logic wait_cmd_pulse, lb_write_enable, stencil_pass, depth_pass, unit_enables, lb_update;
    logic frag_valid, screen_valid, frag_inside, chroma_in_bounds_in, chroma_in_bounds_out;
    logic convert_enable, suppress_plot, suppress_texture, texel_pass;
    logic [11:0] wr_tag, rd_tag;
    logic [31:0] wr_data, rd_data, texel_in, texel_converted, texel_value, rdat;
    logic [15:0] frag_x, frag_y, screen_x, screen_y;
    logic [27:0] depth_start;
    logic rack, rref;
    bit ok;
    int fail_count = 0;
    int tests_run = 0;

    rrf_front_end dut (.clk, .rst, .wr_valid, .wr_ready, .wr_tag, .wr_data, .rd_valid, .rd_tag,
        .rd_data, .rd_ack, .rd_refused, .fb_writes_pending, .pipe_stall, .wait_cmd_pulse,
        .lb_write_enable, .stencil_pass, .depth_pass, .unit_enables, .lb_update, .frag_valid,
        .frag_x, .frag_y, .screen_x, .screen_y, .screen_valid, .frag_inside, .texel_in,
        .texel_converted, .chroma_in_bounds_in, .chroma_in_bounds_out, .texel_value,
        .convert_enable, .suppress_plot, .suppress_texture, .texel_pass, .depth_start);
    rrf_host_model host (.clk, .wr_ready, .rd_data, .rd_ack, .rd_refused, .wr_valid, .wr_tag,
        .wr_data, .rd_valid, .rd_tag);

    always #25 clk = ~clk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic put(input logic [11:0] t, input logic [31:0] d);
        host.wr(t, d, ok);
        if (!ok) begin
            fail_count++;
            end_of_test();
        end
    endtask : put
    task automatic get(input logic [11:0] t, input logic [31:0] exp, input logic refd);
        host.rd(t, rdat, rack, rref);
        chk({30'h0, rack, rref}, {30'h0, 1'b1, refd});
        chk(rdat, exp);
    endtask : get

    task automatic t_regs();
        logic [11:0] tg [8] = '{12'h015, 12'h019, 12'h039, 12'h130, 12'h136, 12'h137,
            12'h1e0, 12'h0c0};
        int i;
        get(12'h019, 32'h0, 1'b0);
        for (i = 0; i < 8; i++) put(tg[i], 32'hc3a5_0000 + i);
        put(12'h0ff, 32'hffff_ffff);
        host.idle();
        for (i = 0; i < 8; i++) get(tg[i], 32'hc3a5_0000 + i, 1'b0);
        get(12'h017, 32'h0, 1'b1);
        get(12'h0ff, 32'h0, 1'b1);
        $display("test regs done");
    endtask : t_regs
    task automatic t_wait();
        int n;
        @(negedge clk);
        fb_writes_pending = 1'b1;
        put(12'h017, 32'hffff_ffff);
        host.idle();
        repeat (4) @(negedge clk);
        chk({30'h0, pipe_stall, wr_ready}, 32'h2);
        fb_writes_pending = 1'b0;
        for (n = 0; n < 3 && pipe_stall === 1'b1; n++) @(negedge clk);
        chk({30'h0, pipe_stall, wr_ready}, 32'h1);
        $display("test wait done");
    endtask : t_wait
    task automatic lbv(input logic [3:0] v, input logic e);
        @(negedge clk);
        {lb_write_enable, stencil_pass, depth_pass, unit_enables} = v;
        #1;
        chk({31'h0, lb_update}, {31'h0, e});
    endtask : lbv
    task automatic t_lb();
        put(12'h130, 32'h0000_0008);
        host.idle();
        lbv(4'h8, 1'b1);
        lbv(4'h7, 1'b0);
        put(12'h130, 32'h0);
        host.idle();
        lbv(4'hf, 1'b1);
        lbv(4'hb, 1'b0);
        put(12'h130, 32'h0004_0008);
        host.idle();
        lbv(4'hf, 1'b0);
        lbv(4'h7, 1'b0);
        $display("test localbuffer done");
    endtask : t_lb
    task automatic frag(input logic [15:0] x, input logic [15:0] y, input logic ins);
        @(negedge clk);
        {frag_valid, frag_x, frag_y} = {1'b1, x, y};
        @(negedge clk);
        frag_valid = 1'b0;
        chk({screen_y, screen_x}, {y + 16'h3, x + 16'h10});
        chk({30'h0, screen_valid, frag_inside}, {30'h0, 1'b1, ins});
    endtask : frag
    task automatic t_frag();
        put(12'h039, 32'h0003_0010);
        put(12'h019, 32'h0014_0005);
        put(12'h015, 32'h000a_0ffe);
        host.idle();
        frag(16'h4, 16'h0, 1'b0);
        frag(16'h5, 16'hfffe, 1'b1);
        frag(16'h14, 16'ha, 1'b1);
        frag(16'h15, 16'ha, 1'b0);
        frag(16'h7, 16'hfffd, 1'b0);
        $display("test fragment done");
    endtask : t_frag
    task automatic t_chroma();
        int k;
        logic en, sel, fl;
        {texel_in, texel_converted} = {32'h0123_4567, 32'h89ab_cdef};
        for (k = 0; k < 64; k++) begin
            en = k[2] ^ k[4];
            put(12'h1e0, {26'h0, k[3] ^ k[5], k[3], k[2], k[1:0], en});
            host.idle();
            {chroma_in_bounds_in, chroma_in_bounds_out} = {k[4], k[5]};
            @(negedge clk);
            sel = k[2] ? k[5] : k[4];
            fl = (k[1:0] == 2'd1 && !sel) || (k[1:0] == 2'd2 && sel);
            chk({29'h0, convert_enable, suppress_plot, suppress_texture},
                {29'h0, en, fl & !k[3], fl & k[3]});
            chk({31'h0, texel_pass}, {31'h0, !((k[3] ^ k[5]) && fl)});
            chk(texel_value, en ? 32'h89ab_cdef : 32'h0123_4567);
        end
        $display("test chroma done");
    endtask : t_chroma
    task automatic t_depth();
        put(12'h136, 32'h0001_2345);
        put(12'h137, 32'hffe0_0000);
        host.idle();
        chk({4'h0, depth_start}, {4'h0, 17'h12345, 11'h7ff});
        put(12'h136, 32'hfffe_8001);
        put(12'h137, 32'h001f_ffff);
        host.idle();
        chk({4'h0, depth_start}, {4'h0, 17'h08001, 11'h000});
        $display("test depth done");
    endtask : t_depth

    initial begin
        {fb_writes_pending, lb_write_enable, stencil_pass, depth_pass, unit_enables} = 5'h0;
        {frag_valid, chroma_in_bounds_in, chroma_in_bounds_out} = 3'h0;
        {frag_x, frag_y, texel_in, texel_converted} = 96'h0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_regs();
        t_wait();
        t_lb();
        t_frag();
        t_chroma();
        t_depth();
        end_of_test();
    end
endmodule : render_register_front_end_bench
